// ==== hdl/buck_status_control_regs.sv ====
// Register bank, I2C target and start sequencer of the step-down converter
`timescale 1ns/1ps
`default_nettype none
module buck_status_control_regs
  import buck_regs_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_CYCLES,
  parameter int unsigned SS_CYCLES = SS_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // I2C pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Device pins
  input wire logic en_pin,
  input wire logic select_pin,
  // Analog comparators
  input wire cmp_t cmp_in,
  // Analog control
  output logic converter_on,
  output logic power_good,
  output logic high_select_setting,
  output logic [2:0] fall_rate_code,
  output logic [1:0] softstart_time_code
);
  core_t cur_ff, nxt_ff;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] status, rdata, rx_byte;
  logic en_req, tick, swrst;
  // ----------------------------------------
  // Bus conditions and read mux
  // ----------------------------------------
  assign scl_rise = scl && !cur_ff.scl_prev;
  assign scl_fall = !scl && cur_ff.scl_prev;
  assign start_c = scl && cur_ff.scl_prev && cur_ff.sda_prev && !sda_in;
  assign stop_c = scl && cur_ff.scl_prev && !cur_ff.sda_prev && sda_in;
  assign rx_byte = cur_ff.shreg;
  // Read-only, built from hardware state and the restart flag that a soft reset sets
  assign status = {cur_ff.pgood, cur_ff.sync.uvlo, cur_ff.sync.ovp, cur_ff.sync.ramp_up,
                   cur_ff.sync.ramp_dn, cur_ff.restart, cur_ff.sync.ovt, cur_ff.conv_on};
  always_comb begin
    unique case (cur_ff.ptr)
      ADDR_STATUS: rdata = status;
      ADDR_CTRL2: rdata = cur_ff.ctrl;
      ADDR_DELAY: rdata = {2'b00, cur_ff.delay};
      default: rdata = 8'h00;
    endcase
  end
  assign en_req = en_pin && (select_pin ? cur_ff.ctrl[EN_HI_BIT] : cur_ff.ctrl[EN_LO_BIT]);
  assign tick = cur_ff.tick_cnt == CNT_W'(MS_TICK_CYCLES - 1);
  assign swrst = cur_ff.i2c == I_RX && scl_fall && cur_ff.byte_done && cur_ff.have_ptr
                 && cur_ff.ptr == ADDR_CTRL1 && rx_byte[SWRST_BIT];
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.scl_prev = scl;
    nxt_ff.sda_prev = sda_in;
    nxt_ff.meta = cmp_in;
    nxt_ff.sync = cur_ff.meta;
    // I2C target
    if (start_c) begin
      nxt_ff.i2c = I_ADDR;
      nxt_ff.bitcnt = 3'h0;
      nxt_ff.byte_done = 1'b0;
      nxt_ff.have_ptr = 1'b0;
      nxt_ff.sda_oe = 1'b0;
    end else if (stop_c) begin
      nxt_ff.i2c = I_IDLE;
      nxt_ff.sda_oe = 1'b0;
    end else begin
      unique case (cur_ff.i2c)
        I_IDLE: nxt_ff.sda_oe = 1'b0;
        I_ADDR, I_RX: begin
          if (scl_rise && !cur_ff.byte_done) begin
            nxt_ff.shreg = {cur_ff.shreg[6:0], sda_in};
            nxt_ff.bitcnt = cur_ff.bitcnt + 3'h1;
            nxt_ff.byte_done = cur_ff.bitcnt == 3'h7;
          end else if (scl_fall && cur_ff.byte_done) begin
            nxt_ff.byte_done = 1'b0;
            nxt_ff.sda_oe = 1'b1;
            if (cur_ff.i2c == I_ADDR) begin
              nxt_ff.rd = rx_byte[0];
              nxt_ff.i2c = rx_byte[7:1] == I2C_ADDR ? I_AACK : I_IDLE;
              nxt_ff.sda_oe = rx_byte[7:1] == I2C_ADDR;
            end else begin
              nxt_ff.i2c = I_RACK;
              if (!cur_ff.have_ptr) begin
                nxt_ff.ptr = rx_byte;
                nxt_ff.have_ptr = 1'b1;
              end else begin
                nxt_ff.ptr = cur_ff.ptr + 8'h01;
                if (cur_ff.ptr == ADDR_CTRL2) begin
                  nxt_ff.ctrl = rx_byte;
                  nxt_ff.ctrl[RSVD_BIT] = 1'b0;
                end
                if (cur_ff.ptr == ADDR_DELAY) begin
                  nxt_ff.delay = rx_byte[5:0];
                end
              end
            end
          end
        end
        I_AACK, I_RACK: begin
          if (scl_fall) begin
            nxt_ff.bitcnt = 3'h0;
            if (cur_ff.i2c == I_AACK && cur_ff.rd) begin
              nxt_ff.i2c = I_TX;
              nxt_ff.shreg = {rdata[6:0], 1'b0};
              nxt_ff.sda_oe = !rdata[7];
              nxt_ff.ptr = cur_ff.ptr + 8'h01;
            end else begin
              nxt_ff.i2c = I_RX;
              nxt_ff.sda_oe = 1'b0;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            nxt_ff.bitcnt = cur_ff.bitcnt + 3'h1;
            nxt_ff.shreg = {cur_ff.shreg[6:0], 1'b0};
            nxt_ff.sda_oe = cur_ff.bitcnt != 3'h7 && !cur_ff.shreg[7];
            if (cur_ff.bitcnt == 3'h7) begin
              nxt_ff.i2c = I_TACK;
            end
          end
        end
        I_TACK: begin
          if (scl_rise) begin
            nxt_ff.mack = !sda_in;
          end else if (scl_fall) begin
            nxt_ff.bitcnt = 3'h0;
            nxt_ff.i2c = cur_ff.mack ? I_TX : I_IDLE;
            nxt_ff.shreg = {rdata[6:0], 1'b0};
            nxt_ff.sda_oe = cur_ff.mack && !rdata[7];
            nxt_ff.ptr = cur_ff.mack ? cur_ff.ptr + 8'h01 : cur_ff.ptr;
          end
        end
      endcase
    end
    // Restart flag: a status read clears it, a new restart wins
    if (cur_ff.i2c != I_TX && nxt_ff.i2c == I_TX && cur_ff.ptr == ADDR_STATUS
        || cur_ff.i2c == I_TACK && nxt_ff.i2c == I_TX && cur_ff.ptr == ADDR_STATUS) begin
      nxt_ff.restart = 1'b0;
    end
    if (swrst) begin
      nxt_ff.ctrl = CTRL2_RST;
      nxt_ff.delay = DELAY_RST;
      nxt_ff.restart = 1'b1;
    end
    // Start sequencer
    nxt_ff.tick_cnt = tick ? '0 : cur_ff.tick_cnt + CNT_W'(1);
    unique case (cur_ff.seq)
      S_OFF: begin
        if (en_req) begin
          nxt_ff.seq = S_DELAY;
          nxt_ff.tick_cnt = '0;
          nxt_ff.ms_cnt = 6'h00;
        end
      end
      S_DELAY: begin
        if (!en_req) begin
          nxt_ff.seq = S_OFF;
        end else if (cur_ff.ms_cnt == cur_ff.delay) begin
          nxt_ff.seq = S_SOFT;
          nxt_ff.ss_cnt = '0;
        end else if (tick) begin
          nxt_ff.ms_cnt = cur_ff.ms_cnt + 6'h01;
        end
      end
      S_SOFT: begin
        nxt_ff.ss_cnt = cur_ff.ss_cnt + CNT_W'(1);
        if (!en_req) begin
          nxt_ff.seq = S_OFF;
        end else if (cur_ff.ss_cnt == CNT_W'((SS_CYCLES << cur_ff.ctrl[3:2]) - 1)) begin
          nxt_ff.seq = S_ON;
        end
      end
      S_ON: begin
        if (!en_req) begin
          nxt_ff.seq = S_OFF;
        end
      end
    endcase
    nxt_ff.conv_on = nxt_ff.seq == S_SOFT || nxt_ff.seq == S_ON;
    nxt_ff.pgood = nxt_ff.seq == S_ON;
    nxt_ff.vsel_hi = select_pin;
    nxt_ff.fall_rate = nxt_ff.ctrl[7:5];
    nxt_ff.ss_code = nxt_ff.ctrl[3:2];
  end
  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.i2c <= I_IDLE;
      cur_ff.seq <= S_OFF;
      cur_ff.scl_prev <= 1'b1;
      cur_ff.sda_prev <= 1'b1;
      cur_ff.ctrl <= CTRL2_RST;
      cur_ff.delay <= DELAY_RST;
      cur_ff.fall_rate <= CTRL2_RST[7:5];
      cur_ff.ss_code <= CTRL2_RST[3:2];
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = cur_ff.sda_oe;
  assign converter_on = cur_ff.conv_on;
  assign power_good = cur_ff.pgood;
  assign high_select_setting = cur_ff.vsel_hi;
  assign fall_rate_code = cur_ff.fall_rate;
  assign softstart_time_code = cur_ff.ss_code;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_rsvd_zero: assert property (cur_ff.ctrl[RSVD_BIT] == 1'b0) else $error("reserved bit set");
  a_pgood_needs_on: assert property (status[7] |-> status[0]) else $error("good without enable");
  a_uvlo_sync: assert property (##2 status[6] == $past(cmp_in.uvlo, 2)) else $error("uvlo lag");
  a_ramp_up: assert property (##2 status[4] == $past(cmp_in.ramp_up, 2)) else $error("up ramp lag");
  a_ramp_dn: assert property (##2 status[3] == $past(cmp_in.ramp_dn, 2)) else $error("down ramp lag");
  a_restart_set: assert property (swrst |=> status[2] && cur_ff.ctrl == CTRL2_RST) else $error("restart");
  a_delay_abort: assert property (cur_ff.seq == S_DELAY && !en_req |=> cur_ff.seq == S_OFF) else $error("abort");
  a_enable_drop: assert property (!en_req && cur_ff.seq != S_OFF |=> ##1 !converter_on) else $error("drop");
  a_zero_delay: assert property (cur_ff.seq == S_DELAY && cur_ff.delay == 6'h00 && en_req
                                 |=> cur_ff.seq == S_SOFT) else $error("zero delay");
  a_rate_out: assert property (##1 fall_rate_code == cur_ff.ctrl[7:5]) else $error("rate code");
  c_power_good: cover property (power_good);
  c_soft_reset: cover property (swrst);
  c_read_tx: cover property (cur_ff.i2c == I_TX);
endmodule // buck_status_control_regs
`default_nettype wire

// ==== hdl/buck_regs_pkg.sv ====
// Constants, types and state record of the converter register bank
package buck_regs_pkg;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_CTRL2 = 8'h06;
  localparam logic [7:0] ADDR_DELAY = 8'h07;
  localparam int SWRST_BIT = 2;
  localparam int RSVD_BIT = 4;
  localparam int EN_HI_BIT = 1;
  localparam int EN_LO_BIT = 0;
  localparam logic [7:0] CTRL2_RST = 8'h63;
  localparam logic [5:0] DELAY_RST = 6'h03;
  localparam logic [6:0] I2C_ADDR = 7'h1c; // Arbitrary value
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 10;
  localparam int TICK_US = 1000;
  localparam int SS_UNIT_US = 100;
  localparam int MS_CYCLES = TICK_US * CLK_MHZ;
  localparam int SS_UNIT_CYCLES = SS_UNIT_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [6:0] {
    I_IDLE = 7'h01, I_ADDR = 7'h02, I_AACK = 7'h04, I_RX = 7'h08,
    I_RACK = 7'h10, I_TX = 7'h20, I_TACK = 7'h40
  } i2c_state_t;
  typedef enum logic [3:0] {
    S_OFF = 4'h1, S_DELAY = 4'h2, S_SOFT = 4'h4, S_ON = 4'h8
  } seq_state_t;
  typedef struct packed {
    logic uvlo;
    logic ovp;
    logic ovt;
    logic ramp_up;
    logic ramp_dn;
  } cmp_t;
  typedef struct packed {
    i2c_state_t i2c;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic byte_done;
    logic rd;
    logic have_ptr;
    logic [7:0] ptr;
    logic mack;
    logic sda_oe;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] ctrl;
    logic [5:0] delay;
    logic restart;
    cmp_t meta;
    cmp_t sync;
    seq_state_t seq;
    logic [CNT_W-1:0] tick_cnt;
    logic [5:0] ms_cnt;
    logic [CNT_W-1:0] ss_cnt;
    logic conv_on;
    logic pgood;
    logic vsel_hi;
    logic [2:0] fall_rate;
    logic [1:0] ss_code;
  } core_t;
endpackage

// ==== bench/i2c_host_model.sv ====
// I2C host model that drives the register bus
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
  import buck_regs_pkg::*;
(
  // Clock and bus
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  // Read result
  output logic rd_done,
  output logic [7:0] rd_byte
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // SDA moves only while SCL is low
  task automatic xbit(input logic b, output logic s);
    sda_low = !b;
    hw(5);
    scl = 1'b1;
    hw(5);
    s = sda;
    scl = 1'b0;
    hw(2);
  endtask
  task automatic start();
    sda_low = 1'b0;
    hw(5);
    scl = 1'b1;
    hw(5);
    sda_low = 1'b1;
    hw(5);
    scl = 1'b0;
    hw(2);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, a);
  endtask
  task automatic xfer(input logic [6:0] a7, input logic [7:0] p, input logic [7:0] d, input logic rd,
                      output logic ack);
    logic a;
    start();
    wbyte({a7, 1'b0}, ack);
    wbyte(p, a);
    if (rd) begin
      start();
      wbyte({a7, 1'b1}, a);
      for (int i = 7; i >= 0; i--) xbit(1'b1, rd_byte[i]);
      xbit(1'b1, a);
    end else begin
      wbyte(d, a);
    end
    sda_low = 1'b1;
    hw(5);
    scl = 1'b1;
    hw(5);
    sda_low = 1'b0;
    rd_done = rd;
    hw(5);
    rd_done = 1'b0;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench of the converter register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import buck_regs_pkg::*;
  logic sys_clk, nrst, scl, sda_low, rd_done, en_pin, select_pin, ack;
  logic sda_out, sda_oe, conv_on, pgood, hi_sel;
  logic [2:0] fr, r3;
  logic [1:0] ss;
  logic [4:0] c;
  logic [7:0] rd_byte;
  logic [7:0] q[$];
  cmp_t cmp_in;
  int error_cnt = 0;
  int compares = 0;
  int n, seed = 5717;
  wire sda = !(sda_low || (sda_oe && !sda_out));
  buck_status_control_regs #(.MS_TICK_CYCLES(20), .SS_CYCLES(10)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .en_pin(en_pin), .select_pin(select_pin), .cmp_in(cmp_in), .converter_on(conv_on),
    .power_good(pgood), .high_select_setting(hi_sel), .fall_rate_code(fr), .softstart_time_code(ss));
  i2c_host_model i_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .rd_done(rd_done), .rd_byte(rd_byte));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    q.push_back(e);
    i_host.xfer(I2C_ADDR, p, 8'h00, 1'b1, ack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_host.xfer(I2C_ADDR, p, d, 1'b0, ack);
    check({7'h0, ack}, 8'h00);
  endtask
  task automatic cnt_until(input logic which);
    n = 0;
    while ((which ? pgood : conv_on) !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // ----------------------------------------
  // Read scoreboard and watchdog
  // ----------------------------------------
  always @(posedge rd_done) check(rd_byte, q.size() > 0 ? q.pop_front() : ~rd_byte);
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    results();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    en_pin = 1'b0;
    select_pin = 1'b1;
    cmp_in = '0;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    check({5'h0, fr}, 8'h03);
    check({6'h0, ss}, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL2, CTRL2_RST);
    rd(ADDR_DELAY, {2'b00, DELAY_RST});
    i_host.xfer(7'h1d, ADDR_CTRL2, 8'h00, 1'b0, ack);
    check({7'h0, ack}, 8'h01);
    r3 = 3'($random(seed));
    wr(ADDR_CTRL2, {r3, 5'b10111});
    rd(ADDR_CTRL2, {r3, 5'b00111});
    check({5'h0, fr}, {5'h0, r3});
    check({6'h0, ss}, 8'h01);
    wr(ADDR_DELAY, 8'h02);
    rd(ADDR_DELAY, 8'h02);
    en_pin = 1'b1;
    repeat (25) @(negedge sys_clk);
    check({7'h0, conv_on}, 8'h00);
    en_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
    en_pin = 1'b1;
    cnt_until(1'b0);
    check({7'h0, n >= 40 && n <= 43}, 8'h01);
    cnt_until(1'b1);
    check({7'h0, n >= 20 && n <= 22}, 8'h01);
    repeat (2) begin
      c = 5'($random(seed));
      cmp_in = c;
      repeat (4) @(negedge sys_clk);
      rd(ADDR_STATUS, {1'b1, c[4], c[3], c[1], c[0], 1'b0, c[2], 1'b1});
    end
    wr(ADDR_CTRL2, {r3, 5'b00110});
    check({7'h0, conv_on}, 8'h01);
    check({7'h0, hi_sel}, 8'h01);
    select_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({7'h0, conv_on}, 8'h00);
    check({7'h0, hi_sel}, 8'h00);
    en_pin = 1'b0;
    cmp_in = '0;
    wr(ADDR_CTRL1, 8'h04);
    rd(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL2, CTRL2_RST);
    wr(ADDR_STATUS, 8'hff);
    rd(ADDR_STATUS, 8'h00);
    rd(8'h10, 8'h00);
    results();
  end
endmodule // tb
`default_nettype wire
